/* File: src/wrf_regs.sv */
`timescale 1ns/1ps
`default_nettype none
`include "wrf_defs.svh"

// Behaviour
// - Suspend request clears on reset pin, reset-register read or stop; always accessible.
// - Mode bit is needed only for pin-started detection; force-enable alone also enters it; mode alone starts nothing.
// - With mode set, sleep pin becomes detection enable, not power-down request.
// - Mode bit always accessible; cleared only by reset pin or reset-register read.
// - Force-enable bit enters detection; always accessible; cleared by reset or reset read.
// - Received flag raises interrupt only while unmask bit is set.
// - Unmask bit clears on reset pin, reset-register read or stop.
// - Received flag sets when a complete wake-up frame is recognised.
// - Initialization copies transmit ring length code into bits 15:12.
// - Initialization copies receive ring length code into bits 11:8.
// - Ring length readable only in stop or suspend; writes have no effect.
// - Transmit ring length defined only after initialization.
// - Receive ring length defined only after initialization.
// - Ring length bits 7:0 read as zero.
// - Hash filter is four 16-bit words, low word first.
// - Hash filter loads from initialization block or host write.
// - Hash filter accessible only in stop or suspend.
// - Suspend request set only while stop is zero; reads one once suspended.
module wrf_regs (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  // Device control context
  input wire logic stop_i,
  input wire logic reset_reg_rd_i,
  input wire logic suspended_i,
  output logic suspend_req_o,
  // Sleep pin and wake-up detection
  input wire logic sleep_n_i,
  input wire logic wake_frame_seen_i,
  output logic power_down_req_o,
  output logic wake_detect_en_o,
  output logic wake_irq_o,
  // Initialization block load
  input wire logic init_load_i,
  input wire logic [3:0] init_tx_len_i,
  input wire logic [3:0] init_rx_len_i,
  input wire logic [63:0] init_hash_i,
  output logic [63:0] hash_filter_o
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic suspend_q;
  logic mode_q;
  logic force_q;
  logic unmask_q;
  logic received_q;
  logic received_d;
  logic init_done_q;
  wrf_pkg::wrf_len_t tx_len_q;
  wrf_pkg::wrf_len_t rx_len_q;
  wrf_pkg::wrf_word_t hash_q [`WRF_HASH_WORDS];
  logic wr_q;
  logic rd_wait_q;
  wrf_pkg::wrf_addr_t addr_q;
  logic [31:0] hrdata_q;
  logic sleep_meta_q;
  logic sleep_sync_q;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire logic accept = hsel_i & hready_i & htrans_i[1];
  wire logic hi_zero = (haddr_i[31:8] == 24'h000000);
  wire logic wr_ctrl = wr_q & (addr_q == `WRF_ADDR_CTRL);
  wire logic hash_hit = ((addr_q & `WRF_ADDR_HASH_MASK) == `WRF_ADDR_HASH0);
  wire logic [1:0] hash_sel = addr_q[3:2];
  wire logic access_ok = stop_i | suspended_i;
  wire logic soft_clear = reset_reg_rd_i;
  wire logic [15:0] ctrl_rd = {11'h000, received_q, unmask_q, force_q, mode_q, suspend_q & suspended_i};
  wire logic [15:0] ring_rd = (access_ok & init_done_q) ? {tx_len_q, rx_len_q, 8'h00} : `WRF_RST_WORD;
  wire logic [15:0] hash_rd = access_ok ? hash_q[hash_sel] : `WRF_RST_WORD;
  wire logic [15:0] rd_word = (addr_q == `WRF_ADDR_CTRL) ? ctrl_rd :
                              (addr_q == `WRF_ADDR_RING) ? ring_rd :
                              hash_hit ? hash_rd : `WRF_RST_WORD;

  assign hreadyout_o = ~rd_wait_q;
  assign hresp_o = 1'b0;
  assign hrdata_o = hrdata_q;

  // ----------------------------------------
  // Bus phases
  // ----------------------------------------
  // Reads take one wait state so a write just before is already visible.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_q <= 1'b0;
      rd_wait_q <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      wr_q <= accept & hwrite_i & hi_zero;
      rd_wait_q <= accept & ~hwrite_i;
      if (accept) begin
        addr_q <= hi_zero ? haddr_i[7:0] : 8'hff;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hrdata_q <= `WRF_RST_DATA;
    end else if (rd_wait_q) begin
      hrdata_q <= {16'h0000, rd_word};
    end
  end

  // ----------------------------------------
  // Sleep pin synchroniser
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sleep_meta_q <= 1'b1;
      sleep_sync_q <= 1'b1;
    end else begin
      sleep_meta_q <= sleep_n_i;
      sleep_sync_q <= sleep_meta_q;
    end
  end

  // Mode alone does not start detection: it needs the pin or force-enable.
  assign wake_detect_en_o = force_q | (mode_q & ~sleep_sync_q);
  assign power_down_req_o = ~mode_q & ~sleep_sync_q;
  assign wake_irq_o = received_q & unmask_q;
  assign suspend_req_o = suspend_q;

  // ----------------------------------------
  // Control and wake bits
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      suspend_q <= `WRF_RST_BIT;
    end else if (soft_clear | stop_i) begin
      suspend_q <= 1'b0;
    end else if (wr_ctrl) begin
      suspend_q <= hwdata_i[`WRF_BIT_SUSPEND];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_q <= `WRF_RST_BIT;
      force_q <= `WRF_RST_BIT;
    end else if (soft_clear) begin
      mode_q <= 1'b0;
      force_q <= 1'b0;
    end else if (wr_ctrl) begin
      mode_q <= hwdata_i[`WRF_BIT_MODE];
      force_q <= hwdata_i[`WRF_BIT_FORCE];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      unmask_q <= `WRF_RST_BIT;
    end else if (soft_clear | stop_i) begin
      unmask_q <= 1'b0;
    end else if (wr_ctrl) begin
      unmask_q <= hwdata_i[`WRF_BIT_UNMASK];
    end
  end

  // A frame arriving in the clearing cycle is kept: set beats clear.
  always_comb begin
    received_d = received_q;
    if (soft_clear | (wr_ctrl & hwdata_i[`WRF_BIT_RECEIVED])) begin
      received_d = 1'b0;
    end
    if (wake_frame_seen_i) begin
      received_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      received_q <= `WRF_RST_BIT;
    end else begin
      received_q <= received_d;
    end
  end

  // ----------------------------------------
  // Ring length copies
  // ----------------------------------------
  // Host writes never reach these fields.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_len_q <= `WRF_RST_LEN;
      rx_len_q <= `WRF_RST_LEN;
      init_done_q <= 1'b0;
    end else if (init_load_i) begin
      tx_len_q <= init_tx_len_i;
      rx_len_q <= init_rx_len_i;
      init_done_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // Hash filter words
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `WRF_HASH_WORDS; gi++) begin : g_hash
      wire logic host_wr = wr_q & hash_hit & access_ok & (hash_sel == 2'(gi));
      always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          hash_q[gi] <= `WRF_RST_WORD;
        end else if (init_load_i) begin
          hash_q[gi] <= init_hash_i[gi*16 +: 16];
        end else if (host_wr) begin
          hash_q[gi] <= hwdata_i[15:0];
        end
      end
      assign hash_filter_o[gi*16 +: 16] = hash_q[gi];
    end
  endgenerate

endmodule
`default_nettype wire

/* File: src/wrf_defs.svh */
`ifndef WRF_DEFS_SVH
`define WRF_DEFS_SVH

// ----------------------------------------
// Register indices and byte addresses
// ----------------------------------------
`define WRF_IDX_CTRL 8'h05
`define WRF_IDX_RING 8'h06
`define WRF_IDX_HASH0 8'h08
`define WRF_ADDR_CTRL 8'h14
`define WRF_ADDR_RING 8'h18
`define WRF_ADDR_HASH0 8'h20
`define WRF_ADDR_HASH_MASK 8'hf0

// ----------------------------------------
// Field positions
// ----------------------------------------
`define WRF_BIT_SUSPEND 0
`define WRF_BIT_MODE 1
`define WRF_BIT_FORCE 2
`define WRF_BIT_UNMASK 3
`define WRF_BIT_RECEIVED 4
`define WRF_TXLEN_LSB 12
`define WRF_RXLEN_LSB 8
`define WRF_HASH_WORDS 4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define WRF_RST_BIT 1'b0
`define WRF_RST_LEN 4'h0
`define WRF_RST_WORD 16'h0000
`define WRF_RST_DATA 32'h0000_0000

`endif

/* File: src/wrf_pkg.sv */
package wrf_pkg;

  typedef logic [15:0] wrf_word_t;
  typedef logic [3:0] wrf_len_t;
  typedef logic [7:0] wrf_addr_t;

endpackage

/* File: bench/wrf_regs_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module wrf_regs_chk (
  input wire logic sys_clk_i, rstn_i, hsel_i, hready_i, hwrite_i, hreadyout_o, hresp_o,
  input wire logic stop_i, reset_reg_rd_i, init_load_i, suspended_i,
  input wire logic suspend_req_o, wake_irq_o, wake_detect_en_o,
  input wire logic [1:0] htrans_i,
  input wire logic [31:0] hrdata_o,
  input wire logic [63:0] init_hash_i, hash_filter_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  wire rq = hsel_i & hready_i & htrans_i[1];
  property p_stop; stop_i |=> !suspend_req_o && !wake_irq_o; endproperty
  a_stop: assert property (p_stop) else $error("stop left bits set");
  property p_rrd; reset_reg_rd_i |=> !suspend_req_o && !wake_irq_o && !wake_detect_en_o; endproperty
  a_rrd: assert property (p_rrd) else $error("soft reset left bits set");
  property p_rd; rq && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o; endproperty
  a_rd: assert property (p_rd) else $error("read wait state wrong");
  property p_wr; rq && hwrite_i |=> hreadyout_o; endproperty
  a_wr: assert property (p_wr) else $error("write stalled");
  property p_ok; hresp_o == 1'b0 && hrdata_o[31:16] == 16'h0000; endproperty
  a_ok: assert property (p_ok) else $error("bad response or upper data");
  property p_load; init_load_i |=> hash_filter_o == $past(init_hash_i); endproperty
  a_load: assert property (p_load) else $error("hash not loaded");
  property p_hold; !init_load_i && !stop_i && !suspended_i |=> $stable(hash_filter_o); endproperty
  a_hold: assert property (p_hold) else $error("hash changed while running");
  property p_susp; $rose(suspend_req_o) |-> $past(stop_i) == 1'b0; endproperty
  a_susp: assert property (p_susp) else $error("suspend set while stopped");
  cover property (rq && !hwrite_i);
  cover property (init_load_i);
  cover property ($rose(wake_irq_o));
endmodule
bind wrf_regs wrf_regs_chk wrf_regs_chk_i (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .hsel_i(hsel_i),
  .hready_i(hready_i), .hwrite_i(hwrite_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .stop_i(stop_i),
  .reset_reg_rd_i(reset_reg_rd_i), .init_load_i(init_load_i), .suspended_i(suspended_i),
  .suspend_req_o(suspend_req_o), .wake_irq_o(wake_irq_o), .wake_detect_en_o(wake_detect_en_o),
  .htrans_i(htrans_i), .hrdata_o(hrdata_o), .init_hash_i(init_hash_i), .hash_filter_o(hash_filter_o));
`default_nettype wire

/* File: bench/tb_wrf_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_wrf_regs;
  logic sys_clk_i = 0, rstn_i = 0, hsel_i = 0, hwrite_i = 0, stop_i = 0, reset_reg_rd_i = 0;
  logic suspended_i = 0, sleep_n_i = 1, wake_frame_seen_i = 0, init_load_i = 0;
  logic hreadyout_o, hresp_o, suspend_req_o, power_down_req_o, wake_detect_en_o, wake_irq_o;
  logic [1:0] htrans_i = 2'h0;
  logic [2:0] hsize_i = 3'h2;
  logic [3:0] init_tx_len_i = 4'h0, init_rx_len_i = 4'h0;
  logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o, r;
  logic [63:0] init_hash_i = 64'h0, hash_filter_o;
  int n_errors = 0, checks_done = 0;
  wrf_regs wrf_regs_i (.sys_clk_i, .rstn_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i,
    .hready_i(hreadyout_o), .hreadyout_o, .hresp_o, .hrdata_o, .stop_i, .reset_reg_rd_i, .suspended_i,
    .suspend_req_o, .sleep_n_i, .wake_frame_seen_i, .power_down_req_o, .wake_detect_en_o, .wake_irq_o,
    .init_load_i, .init_tx_len_i, .init_rx_len_i, .init_hash_i, .hash_filter_o);
  initial forever #50 sys_clk_i = ~sys_clk_i;
  // --------------------------------
  // Bus tasks
  // --------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    if (n_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Bounded wait: a hung slave ends the run instead of stalling it
  task automatic wt;
    int n;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (hreadyout_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_errors++;
      final_report;
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    hsel_i <= 1'b1;
    haddr_i <= a;
    htrans_i <= 2'h2;
    hwrite_i <= w;
    wt;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    wt;
    r = hrdata_o;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(64'(r), 64'(e));
  endtask
  initial begin
    repeat (12) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    @(posedge sys_clk_i);
    {stop_i, init_load_i, init_tx_len_i, init_rx_len_i} <= {2'b11, 8'ha5};
    init_hash_i <= 64'h4444_3333_2222_1111;
    @(posedge sys_clk_i) init_load_i <= 1'b0;
    rd(32'h18, 32'h0000_a500);
    for (int i = 0; i < 4; i++) rd(32'h20 + 4 * i, 32'h1111 * (i + 1));
    bus(1'b1, 32'h18, 32'hffff);
    rd(32'h18, 32'h0000_a500);
    bus(1'b1, 32'h24, 32'h1234);
    @(negedge sys_clk_i) chk(hash_filter_o, 64'h4444_3333_1234_1111);
    @(posedge sys_clk_i) stop_i <= 1'b0;
    bus(1'b1, 32'h28, 32'hbeef);
    @(negedge sys_clk_i) chk(hash_filter_o, 64'h4444_3333_1234_1111);
    rd(32'h28, 32'h0);
    bus(1'b1, 32'h14, 32'h0f);
    rd(32'h14, 32'h0e);
    chk(64'({hresp_o, suspend_req_o}), 64'h1);
    @(posedge sys_clk_i) suspended_i <= 1'b1;
    rd(32'h14, 32'h0f);
    rd(32'h20, 32'h1111);
    @(posedge sys_clk_i) wake_frame_seen_i <= 1'b1;
    @(posedge sys_clk_i) wake_frame_seen_i <= 1'b0;
    @(negedge sys_clk_i) chk(64'(wake_irq_o), 64'h1);
    bus(1'b1, 32'h14, 32'h07);
    @(negedge sys_clk_i) chk(64'(wake_irq_o), 64'h0);
    rd(32'h14, 32'h17);
    bus(1'b1, 32'h14, 32'h1f);
    rd(32'h14, 32'h0f);
    bus(1'b1, 32'h14, 32'h02);
    @(posedge sys_clk_i) sleep_n_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    @(negedge sys_clk_i) chk(64'({power_down_req_o, wake_detect_en_o}), 64'h1);
    bus(1'b1, 32'h14, 32'h0);
    @(negedge sys_clk_i) chk(64'({power_down_req_o, wake_detect_en_o}), 64'h2);
    @(posedge sys_clk_i) sleep_n_i <= 1'b1;
    bus(1'b1, 32'h14, 32'h0f);
    @(posedge sys_clk_i) stop_i <= 1'b1;
    @(posedge sys_clk_i) stop_i <= 1'b0;
    rd(32'h14, 32'h06);
    @(posedge sys_clk_i) stop_i <= 1'b1;
    bus(1'b1, 32'h14, 32'h01);
    rd(32'h14, 32'h00);
    @(posedge sys_clk_i) stop_i <= 1'b0;
    bus(1'b1, 32'h14, 32'h0f);
    @(posedge sys_clk_i) wake_frame_seen_i <= 1'b1;
    @(posedge sys_clk_i) {wake_frame_seen_i, reset_reg_rd_i} <= 2'b01;
    @(posedge sys_clk_i) reset_reg_rd_i <= 1'b0;
    rd(32'h14, 32'h00);
    bus(1'b1, 32'h100, 32'hffff);
    rd(32'h100, 32'h0);
    rd(32'h30, 32'h0);
    // Reset pin in mid-run must clear the wake controls
    bus(1'b1, 32'h14, 32'h0e);
    @(posedge sys_clk_i) rstn_i <= 1'b0;
    @(posedge sys_clk_i) rstn_i <= 1'b1;
    rd(32'h14, 32'h00);
    final_report;
  end
endmodule
`default_nettype wire
